// [rtl/tmtg_consts.svh]
`ifndef TMTG_CONSTS_SVH
`define TMTG_CONSTS_SVH

// register byte addresses on the processor data bus
`define TMTG_ADDR_ROW_LO 16'h00f4
`define TMTG_ADDR_ROW_HI 16'h00f5
`define TMTG_ADDR_COL 16'h00f6
`define TMTG_ADDR_CTRL 16'h00f7
`define TMTG_ADDR_TMR_LO 16'h00f8
`define TMTG_ADDR_TMR_HI 16'h00f9

// control register fields
`define TMTG_CTRL_MODE_LSB 0
`define TMTG_CTRL_MODE_MSB 2
`define TMTG_CTRL_CLKMODE_BIT 3
`define TMTG_CTRL_ATG_BIT 4
`define TMTG_CTRL_BUS_ACT_BIT 5
`define TMTG_CTRL_TI_BIT 6

// reset values
`define TMTG_CTRL_RESET 8'h00
`define TMTG_ROW_RESET 16'h0000
`define TMTG_COL_RESET 8'h00
`define TMTG_TMR_RESET 16'h0000
`define TMTG_RDATA_RESET 8'h00

// prescaler: one counter tick every 1, 2 or 4 oscillator clocks
`define TMTG_PRE_LAST 2'h3
`define TMTG_STEP_LAST 5'h19

`endif

// [rtl/tmtg_pkg.sv]
package tmtg_pkg;

  // communication mode field encoding
  typedef enum logic [2:0] {
    TMTG_MODE_IDLE = 3'h0,
    TMTG_MODE_INTERVAL = 3'h1,
    TMTG_MODE_PULSE = 3'h2,
    TMTG_MODE_ROW_TONE = 3'h3,
    TMTG_MODE_COL_TONE = 3'h4,
    TMTG_MODE_MODEM = 3'h5,
    TMTG_MODE_MODEM_PRE = 3'h6,
    TMTG_MODE_DUAL_TONE = 3'h7
  } tmtg_mode_e;

  typedef logic [3:0] tmtg_level_t;

endpackage

// [rtl/tmtg_reload_counter.sv]
`timescale 1ns/1ps
`include "tmtg_consts.svh"

module tmtg_reload_counter import tmtg_pkg::*; #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic load_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [W-1:0] value_i,
  // state
  output logic [W-1:0] count_o,
  output logic carry_o
);

  // one extra bit so the counter passes zero to all ones: value+2 ticks per carry
  logic [W:0] cnt_r;
  logic wrap;

  assign wrap = &cnt_r;
  assign carry_o = run_i && tick_i && wrap && !load_i;
  assign count_o = cnt_r[W-1:0];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= {1'b0, value_i};
    end else if (run_i && tick_i) begin
      if (wrap) begin
        cnt_r <= {1'b0, value_i};
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule // tmtg_reload_counter

// [rtl/tmtg_sine_step.sv]
`timescale 1ns/1ps
`include "tmtg_consts.svh"

module tmtg_sine_step import tmtg_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // divider carry
  input wire logic step_i,
  // level code to the resistor network
  output tmtg_level_t level_o
);

  logic [4:0] step_r;

  // step number to level code, one sine cycle over 26 steps
  function automatic tmtg_level_t step_level(input logic [4:0] s);
    tmtg_level_t l;
    l = 4'h8;
    unique case (s)
      5'h00: l = 4'h8;
      5'h01: l = 4'h9;
      5'h02: l = 4'hb;
      5'h03: l = 4'hc;
      5'h04: l = 4'he;
      5'h05: l = 4'hf;
      5'h06: l = 4'hf;
      5'h07: l = 4'hf;
      5'h08: l = 4'hf;
      5'h09: l = 4'he;
      5'h0a: l = 4'hc;
      5'h0b: l = 4'hb;
      5'h0c: l = 4'h9;
      5'h0d: l = 4'h8;
      5'h0e: l = 4'h6;
      5'h0f: l = 4'h4;
      5'h10: l = 4'h3;
      5'h11: l = 4'h1;
      5'h12: l = 4'h0;
      5'h13: l = 4'h0;
      5'h14: l = 4'h0;
      5'h15: l = 4'h0;
      5'h16: l = 4'h1;
      5'h17: l = 4'h3;
      5'h18: l = 4'h4;
      5'h19: l = 4'h6;
      default: l = 4'h8;
    endcase
    return l;
  endfunction

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_r <= 5'h00;
    end else if (step_i) begin
      step_r <= (step_r == `TMTG_STEP_LAST) ? 5'h00 : step_r + 5'h01;
    end
  end

  // without steps the level holds where it stopped
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_o <= 4'h8;
    end else begin
      level_o <= step_level(step_r);
    end
  end

endmodule // tmtg_sine_step

// [rtl/tmtg_timer_tone.sv]
`timescale 1ns/1ps
`include "tmtg_consts.svh"

module tmtg_timer_tone import tmtg_pkg::*; #(
  parameter int ROW_W = 16,
  parameter int COL_W = 8,
  parameter int TMR_W = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // processor data bus
  input wire logic [15:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_rdata_o,
  // pins
  input wire logic rx_carrier_in_i,
  output logic audible_tone_out_o,
  output tmtg_level_t tone_tx_out_row_o,
  output tmtg_level_t tone_tx_out_col_o,
  output logic tone_tx_out_en_o,
  // processor side
  output logic irq_o,
  output logic phi2_tick_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode

  logic [7:0] ctrl_r;
  logic [ROW_W-1:0] row_rx_value_r;
  logic [COL_W-1:0] col_tx_value_r;
  logic [TMR_W-1:0] timer_reload_r;
  tmtg_mode_e comm_mode_field;
  tmtg_mode_e mode_prev_r;
  logic clk_mode;
  logic atg_en;
  logic timer_irq_enable;
  logic ti_prev_r;

  logic [ROW_W-1:0] row_rx_counter;
  logic [COL_W-1:0] col_tx_counter;
  logic [TMR_W-1:0] timer_counter;
  logic row_carry;
  logic col_carry;
  logic timer_carry;

  logic wr_row_lo, wr_row_hi, wr_col, wr_ctrl, wr_tmr_lo, wr_tmr_hi;
  logic rd_row, rd_tmr;

  assign comm_mode_field = tmtg_mode_e'(ctrl_r[`TMTG_CTRL_MODE_MSB:`TMTG_CTRL_MODE_LSB]);
  assign clk_mode = ctrl_r[`TMTG_CTRL_CLKMODE_BIT];
  assign atg_en = ctrl_r[`TMTG_CTRL_ATG_BIT];
  assign timer_irq_enable = ctrl_r[`TMTG_CTRL_TI_BIT];

  assign wr_row_lo = bus_wr_i && (bus_addr_i == `TMTG_ADDR_ROW_LO);
  assign wr_row_hi = bus_wr_i && (bus_addr_i == `TMTG_ADDR_ROW_HI);
  assign wr_col = bus_wr_i && (bus_addr_i == `TMTG_ADDR_COL);
  assign wr_ctrl = bus_wr_i && (bus_addr_i == `TMTG_ADDR_CTRL);
  assign wr_tmr_lo = bus_wr_i && (bus_addr_i == `TMTG_ADDR_TMR_LO);
  assign wr_tmr_hi = bus_wr_i && (bus_addr_i == `TMTG_ADDR_TMR_HI);
  assign rd_row = bus_rd_i &&
                  ((bus_addr_i == `TMTG_ADDR_ROW_LO) || (bus_addr_i == `TMTG_ADDR_ROW_HI));
  assign rd_tmr = bus_rd_i &&
                  ((bus_addr_i == `TMTG_ADDR_TMR_LO) || (bus_addr_i == `TMTG_ADDR_TMR_HI));

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  logic row_active;
  logic row_slow;
  logic row_irq_carry;
  logic row_pulse_mode;
  logic row_tone_mode;
  logic mode_chg;
  logic row_load;
  logic col_load;
  logic timer_load;
  logic timer_run;

  always_comb begin
    row_active = 1'b0;
    row_slow = 1'b0;
    row_irq_carry = 1'b0;
    row_pulse_mode = 1'b0;
    row_tone_mode = 1'b0;
    unique case (comm_mode_field)
      TMTG_MODE_IDLE: row_active = 1'b0;
      TMTG_MODE_INTERVAL: begin
        row_active = 1'b1;
        row_slow = 1'b1;
        row_irq_carry = 1'b1;
      end
      TMTG_MODE_PULSE: begin
        row_active = 1'b1;
        row_slow = 1'b1;
        row_pulse_mode = 1'b1;
      end
      TMTG_MODE_ROW_TONE: begin
        row_active = 1'b1;
        row_tone_mode = 1'b1;
      end
      TMTG_MODE_COL_TONE: row_active = 1'b0;
      TMTG_MODE_MODEM, TMTG_MODE_MODEM_PRE: begin
        row_active = 1'b1;
        row_slow = 1'b1;
        row_pulse_mode = 1'b1;
      end
      TMTG_MODE_DUAL_TONE: begin
        row_active = 1'b1;
        row_tone_mode = 1'b1;
      end
    endcase
  end

  assign mode_chg = (comm_mode_field != mode_prev_r);
  assign row_load = mode_chg && (comm_mode_field != TMTG_MODE_COL_TONE);
  assign col_load = mode_chg && comm_mode_field[2];
  assign timer_load = timer_irq_enable && !ti_prev_r;
  assign timer_run = timer_irq_enable || clk_mode;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_prev_r <= TMTG_MODE_IDLE;
      ti_prev_r <= 1'b0;
    end else begin
      mode_prev_r <= comm_mode_field;
      ti_prev_r <= timer_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: counters tick at oscillator over 1, 2 or 4

  logic [1:0] pre_r;
  logic tick_div2;
  logic tick_div4;
  logic row_tick;
  logic col_tick;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_r <= 2'h0;
    end else begin
      pre_r <= pre_r + 2'h1;
    end
  end

  assign tick_div2 = pre_r[0];
  assign tick_div4 = (pre_r == `TMTG_PRE_LAST);
  // timers use K=4; sine tones use 26 steps times a divide of 1 or 2
  assign row_tick = row_slow ? tick_div4 : tick_div2;
  assign col_tick = (comm_mode_field == TMTG_MODE_MODEM) ? 1'b1 : tick_div2;

  ////////////////////////////////////////////////////////////////////////////
  // receive carrier synchroniser and edge detect

  logic [2:0] rxc_sync_r;
  logic rxc_level_r;
  logic rxc_edge;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rxc_sync_r <= 3'h0;
    end else begin
      rxc_sync_r <= {rxc_sync_r[1:0], rx_carrier_in_i};
    end
  end

  assign rxc_edge = (rxc_sync_r[1] == rxc_sync_r[2]) && (rxc_sync_r[2] != rxc_level_r);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rxc_level_r <= 1'b0;
    end else if (rxc_sync_r[1] == rxc_sync_r[2]) begin
      rxc_level_r <= rxc_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= `TMTG_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= bus_wdata_i;
    end
  end

  // a carrier edge capture wins over a software write in the same cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row_rx_value_r <= `TMTG_ROW_RESET;
    end else if (row_pulse_mode && rxc_edge) begin
      row_rx_value_r <= row_rx_counter;
    end else if (wr_row_lo) begin
      row_rx_value_r[7:0] <= bus_wdata_i;
    end else if (wr_row_hi) begin
      row_rx_value_r[15:8] <= bus_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      col_tx_value_r <= `TMTG_COL_RESET;
    end else if (wr_col) begin
      col_tx_value_r <= bus_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_reload_r <= `TMTG_TMR_RESET;
    end else if (wr_tmr_lo) begin
      timer_reload_r[7:0] <= bus_wdata_i;
    end else if (wr_tmr_hi) begin
      timer_reload_r[15:8] <= bus_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters

  tmtg_reload_counter #(.W(TMR_W)) u_timer (
    .clk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .load_i(timer_load),
    .run_i(timer_run),
    .tick_i(tick_div4),
    .value_i(timer_reload_r),
    .count_o(timer_counter),
    .carry_o(timer_carry)
  );

  tmtg_reload_counter #(.W(ROW_W)) u_row (
    .clk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .load_i(row_load),
    .run_i(row_active),
    .tick_i(row_tick),
    .value_i(row_rx_value_r),
    .count_o(row_rx_counter),
    .carry_o(row_carry)
  );

  tmtg_reload_counter #(.W(COL_W)) u_col (
    .clk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .load_i(col_load),
    .run_i(comm_mode_field[2]),
    .tick_i(col_tick),
    .value_i(col_tx_value_r),
    .count_o(col_tx_counter),
    .carry_o(col_carry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt latches: a set in the clearing cycle wins

  logic timer_irq_r;
  logic row_irq_r;
  logic timer_irq_set;
  logic row_irq_set;

  assign timer_irq_set = timer_carry && timer_irq_enable;
  assign row_irq_set = (row_irq_carry && row_carry) || (row_pulse_mode && rxc_edge);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_irq_r <= 1'b0;
    end else if (timer_irq_set) begin
      timer_irq_r <= 1'b1;
    end else if (rd_tmr) begin
      timer_irq_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row_irq_r <= 1'b0;
    end else if (row_irq_set) begin
      row_irq_r <= 1'b1;
    end else if (rd_row) begin
      row_irq_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= timer_irq_r || row_irq_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // processor clock: osc/4 normally, timer carry in low power mode

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phi2_tick_o <= 1'b0;
    end else begin
      phi2_tick_o <= clk_mode ? timer_carry : tick_div4;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tone outputs

  logic row_step;
  logic col_step;

  assign row_step = row_tone_mode && row_carry &&
                    ((comm_mode_field == TMTG_MODE_DUAL_TONE) || !atg_en);
  assign col_step = comm_mode_field[2] && col_carry;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      audible_tone_out_o <= 1'b0;
    end else if ((comm_mode_field == TMTG_MODE_ROW_TONE) && atg_en && row_carry) begin
      audible_tone_out_o <= !audible_tone_out_o;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tone_tx_out_en_o <= 1'b0;
    end else begin
      tone_tx_out_en_o <= comm_mode_field[2] ||
                          ((comm_mode_field == TMTG_MODE_ROW_TONE) && !atg_en);
    end
  end

  tmtg_sine_step u_row_step (
    .clk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .step_i(row_step),
    .level_o(tone_tx_out_row_o)
  );

  tmtg_sine_step u_col_step (
    .clk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .step_i(col_step),
    .level_o(tone_tx_out_col_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_rdata_o <= `TMTG_RDATA_RESET;
    end else if (bus_rd_i) begin
      unique case (bus_addr_i)
        `TMTG_ADDR_ROW_LO: bus_rdata_o <= row_rx_value_r[7:0];
        `TMTG_ADDR_ROW_HI: bus_rdata_o <= row_rx_value_r[15:8];
        `TMTG_ADDR_COL: bus_rdata_o <= col_tx_value_r;
        `TMTG_ADDR_CTRL: bus_rdata_o <= {1'b0, ctrl_r[6:0]};
        `TMTG_ADDR_TMR_LO: bus_rdata_o <= timer_counter[7:0];
        `TMTG_ADDR_TMR_HI: bus_rdata_o <= timer_counter[15:8];
        default: bus_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule // tmtg_timer_tone

// [dv/tmtg_timer_tone_assertions.sv]
`timescale 1ns/1ps
`include "tmtg_consts.svh"

module tmtg_timer_tone_checker import tmtg_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // processor data bus
  input wire logic [15:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_rdata_o,
  // pins
  input wire logic rx_carrier_in_i,
  input wire logic audible_tone_out_o,
  input wire tmtg_level_t tone_tx_out_row_o,
  input wire tmtg_level_t tone_tx_out_col_o,
  input wire logic tone_tx_out_en_o,
  // processor side
  input wire logic irq_o,
  input wire logic phi2_tick_o
);
  logic [7:0] ctl_r;
  logic [2:0] quiet_r;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////
  // shadow of the control register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_r <= 8'h00;
    end else if (bus_wr_i && bus_addr_i == `TMTG_ADDR_CTRL) begin
      ctl_r <= bus_wdata_i;
    end
  end
  // cycles spent in modes 0 to 2, which step no sine counter
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      quiet_r <= 3'h0;
    end else if (ctl_r[2:0] > 3'h2) begin
      quiet_r <= 3'h0;
    end else if (quiet_r != 3'h7) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end
  function automatic logic irq_mode(logic [2:0] m);
    return m inside {3'h1, 3'h2, 3'h5, 3'h6};
  endfunction
  ////////////////////////////////////////
  a_rdata_holds: assert property ($past(rst_b_i) && !$past(bus_rd_i) |-> $stable(bus_rdata_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (bus_rd_i && !(bus_addr_i inside {[16'h00f4:16'h00f9]})
    |=> bus_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_read_back: assert property (bus_wr_i && bus_addr_i == `TMTG_ADDR_CTRL ##1 bus_rd_i &&
    bus_addr_i == `TMTG_ADDR_CTRL |=> bus_rdata_o == ($past(bus_wdata_i, 2) & 8'h7f))
    else $error("control read back wrong");
  a_tone_en_map: assert property ($stable(ctl_r) && $past(rst_b_i) |-> tone_tx_out_en_o ==
    (ctl_r[2] || (ctl_r[2:0] == 3'h3 && !ctl_r[4])))
    else $error("tone enable wrong for mode");
  a_irq_has_source: assert property ($rose(irq_o) |-> ctl_r[6] || $past(ctl_r[6]) ||
    $past(ctl_r[6], 2) || irq_mode(ctl_r[2:0]) || irq_mode($past(ctl_r[2:0])) ||
    irq_mode($past(ctl_r[2:0], 2)))
    else $error("interrupt without a source");
  a_row_frozen: assert property (quiet_r >= 3'h4 |-> $stable(tone_tx_out_row_o))
    else $error("row level moved while stopped");
  a_col_frozen: assert property (quiet_r >= 3'h4 |-> $stable(tone_tx_out_col_o))
    else $error("column level moved while stopped");
  a_level_codes: assert property (!(tone_tx_out_row_o inside {4'h2, 4'h5, 4'h7, 4'ha, 4'hd}) &&
    !(tone_tx_out_col_o inside {4'h2, 4'h5, 4'h7, 4'ha, 4'hd}))
    else $error("level code outside the step table");
  a_phi2_cadence: assert property (phi2_tick_o && !ctl_r[3] && !$past(ctl_r[3]) ##1
    !ctl_r[3] [*4] |-> phi2_tick_o)
    else $error("processor tick not every four clocks");
  a_phi2_gap: assert property (phi2_tick_o |=> !phi2_tick_o [*3])
    else $error("processor ticks too close");
  a_atg_source: assert property ($changed(audible_tone_out_o) && $past(rst_b_i) |->
    $past({ctl_r[4], ctl_r[2:0]}) == 4'hb || $past({ctl_r[4], ctl_r[2:0]}, 2) == 4'hb ||
    $past({ctl_r[4], ctl_r[2:0]}, 3) == 4'hb)
    else $error("square wave moved outside its mode");
endmodule // tmtg_timer_tone_checker

bind tmtg_timer_tone tmtg_timer_tone_checker chk_u (.mclk_i, .rst_b_i, .bus_addr_i,
  .bus_wdata_i, .bus_wr_i, .bus_rd_i, .bus_rdata_o, .rx_carrier_in_i, .audible_tone_out_o,
  .tone_tx_out_row_o, .tone_tx_out_col_o, .tone_tx_out_en_o, .irq_o, .phi2_tick_o);

// [dv/tmtg_cpu_model.sv]
`timescale 1ns/1ps

module tmtg_cpu_model (
  // clock
  input wire logic mclk_i,
  // processor data bus
  output logic [15:0] bus_addr_o,
  output logic [7:0] bus_wdata_o,
  output logic bus_wr_o,
  output logic bus_rd_o
);
  initial begin
    bus_addr_o = 16'h0000;
    bus_wdata_o = 8'h00;
    bus_wr_o = 1'b0;
    bus_rd_o = 1'b0;
  end
  // one byte transfer per clock, launched at the falling edge and held to the next
  task automatic op(input logic wr, input logic rd, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    bus_wr_o = wr;
    bus_rd_o = rd;
    bus_addr_o = a;
    bus_wdata_o = d;
  endtask
  // released address and data lines show the inverse of their last value; strobes go low
  task automatic idle();
    op(1'b0, 1'b0, ~bus_addr_o, ~bus_wdata_o);
  endtask
endmodule // tmtg_cpu_model

// [dv/tmtg_timer_tone_bench.sv]
`timescale 1ns/1ps
`include "tmtg_consts.svh"

module tmtg_timer_tone_bench;
  logic mclk_i, rst_b_i, rx_carrier_in_i, bus_wr_i, bus_rd_i, audible_tone_out_o;
  logic tone_tx_out_en_o, irq_o, phi2_tick_o;
  logic [15:0] bus_addr_i;
  logic [7:0] bus_wdata_i, bus_rdata_o, lv, fz;
  logic [3:0] row, col;
  logic [31:0] d;
  logic [8:0] exp_q[$];
  logic rd_q = 1'b0;
  int num_errors = 0, tests_run = 0, cyc = 0, v, c;
  realtime t_hit = 0, t0;

  tmtg_timer_tone dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o), .rx_carrier_in_i(rx_carrier_in_i),
    .audible_tone_out_o(audible_tone_out_o), .tone_tx_out_row_o(row),
    .tone_tx_out_col_o(col), .tone_tx_out_en_o(tone_tx_out_en_o), .irq_o(irq_o),
    .phi2_tick_o(phi2_tick_o));
  tmtg_cpu_model cpu_u (.mclk_i(mclk_i), .bus_addr_o(bus_addr_i), .bus_wdata_o(bus_wdata_i),
    .bus_wr_o(bus_wr_i), .bus_rd_o(bus_rd_i));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] e, input string m);
    tests_run++;
    if (got !== e) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, e);
    end
  endtask
  task automatic chk_int(input int got, input int e, input string m);
    tests_run++;
    if (got != e) begin
      num_errors++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, m, got, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] dt);
    cpu_u.op(1'b1, 1'b0, a, dt);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic chk);
    exp_q.push_back({chk, e});
    cpu_u.op(1'b0, 1'b1, a, 8'h00);
  endtask
  // waits for an event on one output: irq rise, tick, square wave edge, column or row wrap
  task automatic wait_evt(input int sel);
    logic [10:0] p, q;
    int n;
    logic h;
    n = 0;
    q = {irq_o, phi2_tick_o, audible_tone_out_o, row, col};
    do begin
      p = q;
      @(negedge mclk_i);
      q = {irq_o, phi2_tick_o, audible_tone_out_o, row, col};
      n++;
      case (sel)
        0: h = q[10] === 1'b1 && p[10] === 1'b0;
        1: h = q[9] === 1'b1 && p[9] === 1'b0;
        2: h = q[8] !== p[8];
        3: h = q[3:0] === 4'h8 && p[3:0] === 4'h6;
        default: h = q[7:4] === 4'h8 && p[7:4] === 4'h6;
      endcase
    end while (!h && n < 20000);
    t_hit = $realtime;
    if (!h) begin
      $display("mismatch at %0t: event wait timed out", $time);
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic period(input int sel, input int e, input logic [15:0] ca, input string m);
    for (int i = 0; i < 3; i++) begin
      t0 = t_hit;
      if (sel == 0) begin
        rd(ca, 8'(e / 4 - 2), i > 0);
        rd(`TMTG_ADDR_TMR_LO, 8'h00, 1'b0);
        cpu_u.idle();
      end
      wait_evt(sel);
    end
    chk_int(int'((t_hit - t0) / 10.0), e, m);
    $display("test %s done", m);
  endtask
  ////////////////////////////////////////
  always @(posedge mclk_i) begin
    rd_q <= bus_rd_i;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      $display("mismatch at %0t: run timed out", $time);
      num_errors++;
      end_of_test();
    end
  end
  // read answers land one cycle after the read edge
  always @(negedge mclk_i) begin
    if (rd_q === 1'b1 && exp_q.size() > 0) begin
      lv = exp_q[0][7:0];
      if (exp_q.pop_front() & 9'h100) chk8(bus_rdata_o, lv, "read data");
    end
  end

  initial begin
    rst_b_i = 1'b0;
    rx_carrier_in_i = 1'b0;
    void'($urandom(76));
    repeat (8) @(negedge mclk_i);
    chk8({irq_o, phi2_tick_o, audible_tone_out_o, tone_tx_out_en_o, row}, 8'h08, "reset");
    chk8({4'h0, col}, 8'h08, "reset column");
    rst_b_i = 1'b1;
    period(1, 4, 16'h0000, "fast tick");
    d = $urandom;
    v = $urandom_range(2, 9);
    c = $urandom_range(1, 6);
    wr(`TMTG_ADDR_ROW_LO, d[7:0]);
    wr(`TMTG_ADDR_ROW_HI, d[15:8]);
    wr(`TMTG_ADDR_COL, d[23:16]);
    wr(16'h00fa, 8'h5a);
    rd(`TMTG_ADDR_ROW_LO, d[7:0], 1'b1);
    rd(`TMTG_ADDR_ROW_HI, d[15:8], 1'b1);
    rd(`TMTG_ADDR_COL, d[23:16], 1'b1);
    rd(16'h00fa, 8'h00, 1'b1);
    rd(16'h00f3, 8'h00, 1'b1);
    wr(`TMTG_ADDR_CTRL, d[31:24]);
    rd(`TMTG_ADDR_CTRL, d[31:24] & 8'h7f, 1'b1);
    wr(`TMTG_ADDR_CTRL, 8'h00);
    cpu_u.idle();
    $display("test registers done");
    // reload first, then enable the timer interrupt
    wr(`TMTG_ADDR_TMR_LO, 8'(v));
    wr(`TMTG_ADDR_TMR_HI, 8'h00);
    wr(`TMTG_ADDR_CTRL, 8'h40);
    period(0, 4 * (v + 2), `TMTG_ADDR_TMR_LO, "timer interval");
    rd(`TMTG_ADDR_TMR_HI, 8'h00, 1'b0);
    cpu_u.idle();
    repeat (2) @(negedge mclk_i);
    chk8({7'h0, irq_o}, 8'h00, "timer read clear");
    $display("test timer clear done");
    wr(`TMTG_ADDR_CTRL, 8'h08);
    cpu_u.idle();
    period(1, 4 * (v + 2), 16'h0000, "low power tick");
    wr(`TMTG_ADDR_ROW_LO, 8'(v));
    wr(`TMTG_ADDR_ROW_HI, 8'h00);
    wr(`TMTG_ADDR_CTRL, 8'h01);
    period(0, 4 * (v + 2), `TMTG_ADDR_ROW_LO, "row interval");
    wr(`TMTG_ADDR_CTRL, 8'h02);
    for (int i = 0; i < 2; i++) begin
      rd(`TMTG_ADDR_ROW_LO, 8'h00, 1'b0);
      cpu_u.idle();
      repeat ($urandom_range(20, 40)) @(negedge mclk_i);
      rx_carrier_in_i = ~rx_carrier_in_i;
      t0 = $realtime;
      wait_evt(0);
      chk_int(int'((t_hit - t0) / 10.0) inside {[3:7]}, 1, "carrier edge interrupt");
    end
    $display("test carrier done");
    rd(`TMTG_ADDR_ROW_LO, 8'h00, 1'b0);
    // carrier captures overwrote the row value
    wr(`TMTG_ADDR_ROW_LO, 8'(v));
    wr(`TMTG_ADDR_ROW_HI, 8'h00);
    wr(`TMTG_ADDR_CTRL, 8'h13);
    cpu_u.idle();
    period(2, 2 * (v + 2), 16'h0000, "square wave");
    chk8({7'h0, tone_tx_out_en_o}, 8'h00, "square wave tone off");
    wr(`TMTG_ADDR_COL, 8'(c));
    for (int m = 3; m < 8; m++) begin
      wr(`TMTG_ADDR_CTRL, 8'(m));
      cpu_u.idle();
      if (m >= 4) period(3, 26 * (m == 5 ? 1 : 2) * (c + 2), 0, "column tone");
      if (m == 3 || m == 7) period(4, 52 * (v + 2), 0, "row tone");
      if (m == 4) chk8({7'h0, irq_o}, 8'h00, "column tone quiet");
      chk8({7'h0, tone_tx_out_en_o}, 8'h01, "tone enable");
    end
    wr(`TMTG_ADDR_CTRL, 8'h00);
    cpu_u.idle();
    repeat (5) @(negedge mclk_i);
    fz = {row, col};
    repeat (40) @(negedge mclk_i);
    chk8({row, col}, fz, "frozen level");
    $display("test frozen done");
    end_of_test();
  end
endmodule // tmtg_timer_tone_bench
